// File: hw/arf_pkg.sv
// package for the converter result and status flag block
// assumes a single 100 MHz clock domain and an APB3 register bus
package arf_pkg;
   localparam int NCH = 8;
   localparam int DW = 10;
   localparam int CHW = 3;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_MODE = 12'h004;
   localparam logic [11:0] OFS_CHEN = 12'h010;
   localparam logic [11:0] OFS_CHDIS = 12'h014;
   localparam logic [11:0] OFS_CHSR = 12'h018;
   localparam logic [11:0] OFS_STAT = 12'h01c;
   localparam logic [11:0] OFS_LAST = 12'h020;
   localparam logic [11:0] OFS_IEN = 12'h024;
   localparam logic [11:0] OFS_ICLR = 12'h028;
   localparam logic [11:0] OFS_ISR = 12'h02c;
   localparam logic [11:0] OFS_ID = 12'h03c;
   localparam logic [11:0] OFS_RES0 = 12'h030;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_START = 1;
   localparam int MODE_SLEEP = 5;
   localparam int ST_RESULT_READY_FLAG = 16;
   localparam int ST_GOVR = 17;
   localparam int ST_OVR = 8;
   localparam int LAST_CH = 12;
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_OVR = 1;
   // arbitrary identification value
   localparam logic [31:0] ID_VALUE = 32'h0000_a5c1;
   localparam logic [NCH-1:0] ZERO_CH = '0;

   typedef enum logic [1:0] {ARF_IDLE, ARF_BUSY, ARF_SLEEP} arf_mode_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } arf_apb_req_s;

   typedef struct packed {
      logic valid;
      logic [CHW-1:0] ch;
      logic [DW-1:0] data;
   } arf_conv_s;

   typedef struct packed {
      arf_mode_e mode;
      logic sleep_sel;
      logic [NCH-1:0] ch_en;
      logic [NCH-1:0] eoc;
      logic [NCH-1:0] ovr;
      logic result_ready_flag;
      logic govr;
      logic [DW-1:0] last;
      logic [CHW-1:0] last_ch;
      logic [NCH-1:0][DW-1:0] res;
      logic [IRQ_W-1:0] ist;
      logic [IRQ_W-1:0] ien;
      logic [31:0] prdata;
   } arf_state_s;
endpackage

// File: hw/arf_flags.sv
// converter result registers, completion, ready and overrun flags
// assumes the conversion core reports completions on the same clock
//
// What this block does
// - ready flag clears only on last-result read
// - completion stores both results, sets flags
// - result read clears that channel's completion
// - read clears only its own channel flag
// - completion with ready set raises general overrun
// - status read resets general overrun, set wins
// - completion with own flag set: channel overrun
// - status read resets channel overruns, set wins
// - ready rises only when data stored
// - idle sleep selection waits for next conversion
`timescale 1ns/1ns
module arf_flags
   import arf_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic conv_valid_i,
   input wire logic [CHW-1:0] conv_ch_i,
   input wire logic [DW-1:0] conv_data_i,
   output logic conv_start_o,
   output logic sleep_o,
   output logic irq_o
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [NCH-1:0] onehot(input logic [CHW-1:0] c);
      logic [NCH-1:0] v;
      v = ZERO_CH;
      v[c] = 1'b1;
      return v;
   endfunction

   function automatic logic is_res(input logic [11:0] a);
      return a >= OFS_RES0 && a < OFS_RES0 + 12'(4 * NCH) && a[1:0] == 2'b00
         && a != OFS_ID;
   endfunction

   arf_state_s st;
   arf_state_s next_st;
   arf_apb_req_s rq;
   arf_conv_s cv;
   logic acc;
   logic rd;
   logic wr;
   logic mapped;
   logic [CHW-1:0] rch;
   logic done;
   logic [NCH-1:0] done_oh;

   assign rq = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};
   assign cv = '{conv_valid_i, conv_ch_i, conv_data_i};
   assign acc = rq.psel && rq.penable;
   assign rd = acc && !rq.pwrite;
   assign wr = acc && rq.pwrite;
   assign rch = CHW'((rq.paddr - OFS_RES0) >> 2);
   // a completion on a disabled channel stores nothing
   assign done = cv.valid && st.ch_en[cv.ch];
   assign done_oh = done ? onehot(cv.ch) : ZERO_CH;

   always_comb begin
      unique case (rq.paddr)
         OFS_CTRL, OFS_MODE, OFS_CHEN, OFS_CHDIS, OFS_CHSR, OFS_STAT,
         OFS_LAST, OFS_IEN, OFS_ICLR, OFS_ISR, OFS_ID: mapped = 1'b1;
         default: mapped = is_res(rq.paddr);
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [NCH-1:0] eoc_clr;
      eoc_clr = ZERO_CH;
      next_st = st;
      conv_start_o = 1'b0;
      // clear terms first, set terms after so set wins
      if (rd && is_res(rq.paddr)) begin
         eoc_clr = onehot(rch);
      end
      if (rd && rq.paddr == OFS_LAST) begin
         eoc_clr = onehot(st.last_ch);
         next_st.result_ready_flag = 1'b0;
      end
      next_st.eoc = st.eoc & ~eoc_clr;
      if (rd && rq.paddr == OFS_STAT) begin
         next_st.ovr = ZERO_CH;
         next_st.govr = 1'b0;
      end
      if (wr) begin
         case (rq.paddr)
            OFS_CTRL: begin
               if (rq.pwdata[CTRL_START] && st.mode != ARF_BUSY) begin
                  conv_start_o = 1'b1;
                  next_st.mode = ARF_BUSY;
               end
            end
            OFS_MODE: next_st.sleep_sel = rq.pwdata[MODE_SLEEP];
            OFS_CHEN: next_st.ch_en = st.ch_en | rq.pwdata[NCH-1:0];
            OFS_CHDIS: next_st.ch_en = st.ch_en & ~rq.pwdata[NCH-1:0];
            OFS_IEN: next_st.ien = rq.pwdata[IRQ_W-1:0];
            OFS_ICLR: next_st.ist = st.ist & ~rq.pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
      // sleep is entered only at the end of a conversion, from idle or busy, never on selection alone
      if (cv.valid) begin
         next_st.mode = st.sleep_sel ? ARF_SLEEP : ARF_IDLE;
      end else if (!st.sleep_sel && st.mode == ARF_SLEEP) begin
         next_st.mode = ARF_IDLE;
      end
      if (done) begin
         next_st.res[cv.ch] = cv.data;
         next_st.last = cv.data;
         next_st.last_ch = cv.ch;
         next_st.eoc = next_st.eoc | done_oh;
         next_st.result_ready_flag = 1'b1;
         next_st.ist[IRQ_DONE] = 1'b1;
         if (st.eoc[cv.ch]) begin
            next_st.ovr[cv.ch] = 1'b1;
            next_st.ist[IRQ_OVR] = 1'b1;
         end
         if (st.result_ready_flag) begin
            next_st.govr = 1'b1;
            next_st.ist[IRQ_OVR] = 1'b1;
         end
      end
      next_st.prdata = '0;
      if (rq.psel && !rq.penable && !rq.pwrite) begin
         case (rq.paddr)
            OFS_MODE: next_st.prdata[MODE_SLEEP] = st.sleep_sel;
            OFS_CHSR: next_st.prdata[NCH-1:0] = st.ch_en;
            OFS_STAT: begin
               next_st.prdata[NCH-1:0] = st.eoc;
               next_st.prdata[ST_OVR +: NCH] = st.ovr;
               next_st.prdata[ST_RESULT_READY_FLAG] = st.result_ready_flag;
               next_st.prdata[ST_GOVR] = st.govr;
            end
            OFS_LAST: begin
               next_st.prdata[DW-1:0] = st.last;
               next_st.prdata[LAST_CH +: CHW] = st.last_ch;
            end
            OFS_IEN: next_st.prdata[IRQ_W-1:0] = st.ien;
            OFS_ISR: next_st.prdata[IRQ_W-1:0] = st.ist;
            OFS_ID: next_st.prdata = ID_VALUE;
            default: begin
               if (is_res(rq.paddr)) begin
                  next_st.prdata[DW-1:0] = st.res[rch];
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // read data is latched in setup, so access always ends in one cycle
   assign pready_o = 1'b1;
   assign pslverr_o = acc && !mapped;
   assign prdata_o = st.prdata;
   assign sleep_o = st.mode == ARF_SLEEP;
   assign irq_o = |(st.ist & st.ien);

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_result_ready_flag_res_read: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && is_res(rq.paddr) && !done && st.result_ready_flag |=> st.result_ready_flag)
      else $error("ready flag lost on channel result read");
   a_result_ready_flag_last_clr: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && rq.paddr == OFS_LAST && !done |=> !st.result_ready_flag)
      else $error("ready flag not cleared by last-result read");
   a_result_ready_flag_fall: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      $fell(st.result_ready_flag) |-> $past(rd && rq.paddr == OFS_LAST))
      else $error("ready flag fell without last-result read");
   a_done_stores: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      done |=> st.result_ready_flag && st.eoc[$past(cv.ch)]
      && st.last == $past(cv.data))
      else $error("completion not stored");
   a_res_stored: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      done |=> st.res[$past(cv.ch)] == $past(cv.data))
      else $error("channel result not stored");
   a_last_ch_stored: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      done |=> st.last_ch == $past(cv.ch))
      else $error("last-result channel not stored");
   a_ist_done: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      done |=> st.ist[IRQ_DONE])
      else $error("completion event not latched");
   a_res_read_clr: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && is_res(rq.paddr) && !(done && cv.ch == rch)
      |=> !st.eoc[$past(rch)])
      else $error("completion flag not cleared by result read");
   a_last_read_clr: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && rq.paddr == OFS_LAST && !(done && cv.ch == st.last_ch)
      |=> !st.eoc[$past(st.last_ch)])
      else $error("completion flag not cleared by last-result read");
   a_eoc_hold: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (($past(st.eoc) & ~st.eoc) != ZERO_CH) |-> $past(rd))
      else $error("completion flag fell without a read");
   a_other_eoc_kept: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && is_res(rq.paddr) && done && cv.ch != rch
      |=> st.eoc[$past(cv.ch)])
      else $error("other channel completion flag lost");
   a_res_other_kept: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && is_res(rq.paddr) && !done
      |=> (st.eoc & ~onehot($past(rch))) == ($past(st.eoc) & ~onehot($past(rch))))
      else $error("result read touched another completion flag");
   a_govr_set: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      done && st.result_ready_flag |=> st.govr)
      else $error("general overrun missed");
   a_govr_cause: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      $rose(st.govr) |-> $past(done && st.result_ready_flag))
      else $error("general overrun raised without cause");
   a_ist_ovr: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      done && (st.result_ready_flag || st.eoc[cv.ch]) |=> st.ist[IRQ_OVR])
      else $error("overrun event not latched");
   a_govr_clr: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && rq.paddr == OFS_STAT && !(done && st.result_ready_flag) |=> !st.govr)
      else $error("general overrun not reset by status read");
   a_govr_set_wins: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && rq.paddr == OFS_STAT && done && st.result_ready_flag |=> st.govr)
      else $error("general overrun lost to status read");
   a_govr_fall: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      $fell(st.govr) |-> $past(rd && rq.paddr == OFS_STAT))
      else $error("general overrun fell without status read");
   a_ovr_set: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      done && st.eoc[cv.ch] |=> st.ovr[$past(cv.ch)])
      else $error("channel overrun missed");
   a_ovr_cause: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      ((st.ovr & ~$past(st.ovr)) != ZERO_CH) |-> $past(done))
      else $error("channel overrun raised without completion");
   a_ovr_clr: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && rq.paddr == OFS_STAT && !(done && st.eoc[cv.ch])
      |=> st.ovr == ZERO_CH)
      else $error("channel overrun not reset by status read");
   a_ovr_set_wins: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      rd && rq.paddr == OFS_STAT && done && st.eoc[cv.ch]
      |=> st.ovr[$past(cv.ch)])
      else $error("channel overrun lost to status read");
   a_ovr_fall: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      ((~st.ovr & $past(st.ovr)) != ZERO_CH)
      |-> $past(rd && rq.paddr == OFS_STAT))
      else $error("channel overrun fell without status read");
   a_result_ready_flag_cause: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      !st.result_ready_flag ##1 st.result_ready_flag |-> $past(done))
      else $error("ready flag raised without stored data");
   a_disabled_quiet: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      cv.valid && !st.ch_en[cv.ch]
      |=> st.last == $past(st.last) && st.last_ch == $past(st.last_ch))
      else $error("disabled channel completion stored data");
   a_sleep_wait: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      !sleep_o ##1 sleep_o |-> $past(cv.valid, 1))
      else $error("sleep entered without a completion");
   a_idle_no_sleep: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      st.mode == ARF_IDLE && !cv.valid |=> !sleep_o)
      else $error("sleep entered straight from idle");
   a_sleep_hold: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      sleep_o && st.sleep_sel && !conv_start_o |=> sleep_o)
      else $error("sleep left while still selected");
endmodule

// File: verification/arf_core.sv
// conversion core model facing the flag block
// assumes the bench picks channel and data; one clock
`timescale 1ns/1ns
module arf_core
   import arf_pkg::*;
#(
   parameter int LAT = 4
)(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic go_i,
   input wire logic [CHW-1:0] ch_i,
   input wire logic [DW-1:0] data_i,
   output arf_conv_s conv_o
);
   // ---------------
   // conversion timer
   // ---------------
   logic [7:0] cnt;
   logic fin;
   assign fin = (cnt == 8'h01);
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cnt <= 8'h00;
         conv_o <= '0;
      end else begin
         if (start_i || go_i)
            cnt <= LAT[7:0];
         else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
         conv_o.valid <= fin;
         // buses toggle outside the pulse, never hold stale data
         conv_o.ch <= fin ? ch_i : ~conv_o.ch;
         conv_o.data <= fin ? data_i : ~conv_o.data;
      end
   end
endmodule

// File: verification/tb_top.sv
// self-checking bench for the flag block
// assumes the core model beside it; apb master here
`timescale 1ns/1ns
module tb_top
   import arf_pkg::*;
   ;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic [CHW-1:0] cch = '0;
   logic [DW-1:0] cdat = '0;
   arf_apb_req_s req = '0;
   arf_conv_s conv;
   logic [31:0] prdata, rd;
   logic pready, slverr, serr, start, sleep, irq;
   int err_count = 0;
   int n_compared = 0;
   initial forever #5 mclk = ~mclk;
   arf_flags dut (.mclk_i(mclk), .reset_i(rst), .psel_i(req.psel),
      .penable_i(req.penable), .pwrite_i(req.pwrite),
      .paddr_i(req.paddr), .pwdata_i(req.pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(slverr), .conv_valid_i(conv.valid),
      .conv_ch_i(conv.ch), .conv_data_i(conv.data),
      .conv_start_o(start), .sleep_o(sleep), .irq_o(irq));
   arf_core #(.LAT(4)) core (.mclk_i(mclk), .reset_i(rst),
      .start_i(start), .go_i(go), .ch_i(cch), .data_i(cdat),
      .conv_o(conv));
   // ---------------
   // shared tasks
   // ---------------
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge mclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      serr = slverr;
      req <= '0;
      if (pready !== 1'b1) begin
         err_count++;
         give_verdict;
      end
   endtask
   task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      ap(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task wait_done;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (conv.valid !== 1'b1 && n < 20);
      if (conv.valid !== 1'b1) begin
         err_count++;
         give_verdict;
      end
   endtask
   task fire(input logic [CHW-1:0] c, input logic [DW-1:0] d);
      @(posedge mclk);
      cch <= c;
      cdat <= d;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
   endtask
   task cv(input logic [CHW-1:0] c, input logic [DW-1:0] d);
      fire(c, d);
      wait_done;
   endtask
   // ---------------
   // scenarios
   // ---------------
   task t_store;
      ap(1'b1, OFS_CHEN, 32'h17);
      cv(3'h2, 10'h155);
      rdc("stat", OFS_STAT, 32'h0001_0004);
      rdc("res2", OFS_RES0 + 12'h008, 32'h155);
      rdc("stat", OFS_STAT, 32'h0001_0000);
      rdc("last", OFS_LAST, 32'h2155);
      rdc("stat", OFS_STAT, 32'h0);
      $display("store test done");
   endtask
   task t_overrun;
      cv(3'h2, 10'h001);
      cv(3'h4, 10'h3c0);
      rdc("res4", 12'h040, 32'h3c0);
      rdc("stat", OFS_STAT, 32'h0003_0004);
      rdc("stat", OFS_STAT, 32'h0001_0004);
      rdc("last", OFS_LAST, 32'h43c0);
      rdc("res2", OFS_RES0 + 12'h008, 32'h001);
      rdc("stat", OFS_STAT, 32'h0);
      cv(3'h1, 10'h3ff);
      cv(3'h1, 10'h001);
      rdc("stat", OFS_STAT, 32'h0003_0202);
      rdc("stat", OFS_STAT, 32'h0001_0002);
      rdc("last", OFS_LAST, 32'h1001);
      rdc("stat", OFS_STAT, 32'h0);
      $display("overrun test done");
   endtask
   task t_disabled;
      ap(1'b1, OFS_CHDIS, 32'h02);
      rdc("chen", OFS_CHSR, 32'h15);
      cv(3'h1, 10'h0aa);
      ap(1'b0, OFS_STAT, 32'h0);
      chk("result_ready_flag", 32'h0, rd & 32'h0001_0000);
      rdc("last", OFS_LAST, 32'h1001);
      $display("disabled test done");
   endtask
   // model latency puts the access edge on the completion edge
   task t_collide;
      cv(3'h2, 10'h011);
      fire(3'h2, 10'h022);
      repeat (2) @(posedge mclk);
      rdc("stat", OFS_STAT, 32'h0001_0004);
      rdc("stat", OFS_STAT, 32'h0003_0404);
      rdc("stat", OFS_STAT, 32'h0001_0004);
      fire(3'h4, 10'h033);
      repeat (2) @(posedge mclk);
      rdc("res2", OFS_RES0 + 12'h008, 32'h022);
      rdc("stat", OFS_STAT, 32'h0003_0010);
      rdc("last", OFS_LAST, 32'h4033);
      rdc("stat", OFS_STAT, 32'h0);
      $display("collide test done");
   endtask
   task t_irq;
      ap(1'b1, OFS_IEN, 32'h1);
      @(posedge mclk);
      chk("irq", 32'h1, {31'h0, irq});
      ap(1'b1, OFS_IEN, 32'h0);
      @(posedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
      ap(1'b1, OFS_ICLR, 32'h3);
      ap(1'b1, OFS_IEN, 32'h3);
      @(posedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
      rdc("ien", OFS_IEN, 32'h3);
      rdc("isr", OFS_ISR, 32'h0);
      ap(1'b0, 12'h100, 32'h0);
      chk("slverr", 32'h1, {31'h0, serr});
      chk("unmapped", 32'h0, rd);
      $display("irq test done");
   endtask
   task t_sleep;
      ap(1'b1, OFS_MODE, 32'h20);
      cch <= 3'h0;
      repeat (8) @(posedge mclk);
      chk("sleep", 32'h0, {31'h0, sleep});
      ap(1'b1, OFS_CTRL, 32'h2);
      wait_done;
      @(posedge mclk);
      chk("sleep", 32'h1, {31'h0, sleep});
      $display("sleep test done");
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rdc("stat", OFS_STAT, 32'h0);
      t_store;
      t_overrun;
      t_disabled;
      t_collide;
      t_irq;
      t_sleep;
      give_verdict;
   end
endmodule
